// ---- inc/epg_pkg.sv ----
/*
 * Constants, types and register map of the E1 pattern generator/checker.
 * Assumes a 32-bit APB slave at a 100 MHz system clock.
 */
`default_nettype none
package epg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE     = 8'h00;
    localparam logic [7:0] OFF_TX_CTRL  = 8'h04;
    localparam logic [7:0] OFF_RX_CTRL  = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0c;
    localparam logic [7:0] OFF_ERR_CNT  = 8'h10;
    localparam logic [7:0] OFF_INT_STAT = 8'h14;
    localparam logic [7:0] OFF_INT_CLR  = 8'h18;
    localparam logic [7:0] OFF_INT_EN   = 8'h1c;
    localparam logic [7:0] OFF_OUT_SEL  = 8'h20;

    // Pattern and framing figures
    localparam int LFSR_LEN  = 15;
    localparam int TAP_A     = 14;
    localparam int TAP_B     = 15;
    localparam int SLOT_W    = 5;
    localparam int BIT_IDX_W = 8;
    localparam int WIN_LEN   = 64;
    localparam int WIN_CNT_W = 7;
    localparam logic [6:0] LOSS_ERRS = 7'h06;
    localparam int SYNC_RUN  = 32;
    localparam int ERR_CNT_W = 16;

    // Interrupt bit positions
    localparam int INT_W         = 3;
    localparam int INT_SYNC_GAIN = 0;
    localparam int INT_SYNC_LOSS = 1;
    localparam int INT_BIT_ERR   = 2;

    // Reset values
    localparam logic [3:0]        MODE_RST = 4'h0;
    localparam logic [SLOT_W-1:0] SEL_RST  = 5'h00;
    localparam logic [1:0]        OUT_RST  = 2'h0;

    typedef enum logic [1:0] {
        PM_NORMAL   = 2'b00,
        PM_ONE_SLOT = 2'b01,
        PM_NO_ALIGN = 2'b10,
        PM_ALL      = 2'b11
    } epg_pmode_t;

    typedef struct packed {
        epg_pmode_t tx_mode;
        epg_pmode_t rx_mode;
    } epg_mode_t;

    typedef enum logic {CK_HUNT, CK_SYNC} epg_ck_state_t;
endpackage
`default_nettype wire

// ---- rtl/epg_prbs_top.sv ----
/*
 * E1 pseudo-random pattern generator and checker with APB registers.
 * Assumes line clocks, frame syncs and line data arrive from outside the
 * system clock domain and are far slower than it (2.048 MHz vs 100 MHz).
 */
// Overview of operation
// - Generate and check the 2^15-1 maximal length pattern.
// - Unframed mode fills all 256 bits of every frame.
// - Transmit mode: normal, one slot, slots 1-31, all slots.
// - Receive mode: off, one slot, slots 1-31, all slots unframed.
// - Transmit one-slot mode takes its slot from the transmit slot select.
// - Receive one-slot mode takes its slot from the receive slot select.
// - Sync flag set while checker is locked, cleared on loss.
// - Six or more errors within 64 checked bits drop sync.
// - Non-normal receive mode makes the 16-bit counter count pattern errors.
// - Assigned user output pulses once per bit error while synced.
`timescale 1ns/10ps
`default_nettype none
module epg_prbs_top import epg_pkg::*; #(
    parameter int   SYNC_RUN_P = SYNC_RUN,
    parameter logic INVERT     = 1'b1
) (
    // System
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transmit line
    input  wire logic        tx_line_clk,
    input  wire logic        tx_frame_sync,
    input  wire logic        tx_traffic,
    output logic             tx_line_data,
    // Receive line
    input  wire logic        rx_line_clk,
    input  wire logic        rx_frame_sync,
    input  wire logic        rx_line_data,
    // Framer E-bit error event, system clock domain
    input  wire logic        ebit_error,
    // Status outputs
    output logic             pattern_sync_flag,
    output logic             user_output_a,
    output logic             user_output_b,
    output logic             irq
);
    // Control and status state
    epg_mode_t              mode_ctrl;
    logic [SLOT_W-1:0]      tx_slot_select;
    logic [SLOT_W-1:0]      rx_slot_select;
    logic [1:0]             out_sel;
    logic [INT_W-1:0]       int_stat;
    logic [INT_W-1:0]       int_en;
    logic [ERR_CNT_W-1:0]   err_cnt;

    // Pin synchronisers
    logic [5:0]             pin_meta;
    logic [5:0]             pin_sync;
    logic                   tx_clk_d;
    logic                   rx_clk_d;
    logic                   tx_rise;
    logic                   rx_rise;

    // Transmit side
    logic [BIT_IDX_W-1:0]   tx_idx;
    logic [BIT_IDX_W-1:0]   next_tx_idx;
    logic [LFSR_LEN-1:0]    tx_lfsr;
    logic                   tx_fb;
    logic                   tx_in_slot;

    // Receive side
    logic [BIT_IDX_W-1:0]   rx_idx;
    logic [BIT_IDX_W-1:0]   next_rx_idx;
    logic [LFSR_LEN-1:0]    rx_shift;
    logic                   rx_bit;
    logic                   rx_in_slot;
    logic                   rx_err;
    epg_ck_state_t          ck_state;
    epg_pmode_t             rx_mode_d;
    logic [7:0]             run_cnt;
    logic [WIN_LEN-1:0]     win_hist;
    logic [WIN_CNT_W-1:0]   win_cnt;
    logic [WIN_CNT_W-1:0]   next_win_cnt;
    logic                   err_evt;
    logic                   gain_evt;
    logic                   loss_evt;
    logic                   err_pulse;
    logic                   err_inc;

    // Bus decode
    logic                   wr_en;
    logic                   setup;
    logic [31:0]            rd_mux;
    logic                   rd_err;
    logic [INT_W-1:0]       int_clr;
    logic                   cnt_clr;
    logic [INT_W-1:0]       int_evt;

    // Two-stage synchronisers for every outside pin
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= {tx_line_clk, tx_frame_sync, tx_traffic,
                         rx_line_clk, rx_frame_sync, rx_line_data};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_clk_d <= 1'b0;
            rx_clk_d <= 1'b0;
        end else begin
            tx_clk_d <= pin_sync[5];
            rx_clk_d <= pin_sync[2];
        end
    end

    assign tx_rise = pin_sync[5] & ~tx_clk_d;
    assign rx_rise = pin_sync[2] & ~rx_clk_d;

    // Bit position within the 256-bit frame
    assign next_tx_idx = pin_sync[4] ? '0 : tx_idx + 8'h01;
    assign next_rx_idx = pin_sync[1] ? '0 : rx_idx + 8'h01;

    // Which bits carry the pattern
    always_comb begin
        unique case (mode_ctrl.tx_mode)
            PM_NORMAL:   tx_in_slot = 1'b0;
            PM_ONE_SLOT: tx_in_slot =
                next_tx_idx[7:3] == tx_slot_select;
            PM_NO_ALIGN: tx_in_slot = next_tx_idx[7:3] != 5'h00;
            PM_ALL:      tx_in_slot = 1'b1;
        endcase
    end

    always_comb begin
        unique case (mode_ctrl.rx_mode)
            PM_NORMAL:   rx_in_slot = 1'b0;
            PM_ONE_SLOT: rx_in_slot =
                next_rx_idx[7:3] == rx_slot_select;
            PM_NO_ALIGN: rx_in_slot = next_rx_idx[7:3] != 5'h00;
            PM_ALL:      rx_in_slot = 1'b1;
        endcase
    end

    // Generator
    assign tx_fb = tx_lfsr[TAP_A-1] ^ tx_lfsr[TAP_B-1];

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_idx       <= '0;
            tx_lfsr      <= '1;
            tx_line_data <= 1'b0;
        end else if (tx_rise) begin
            tx_idx <= next_tx_idx;
            if (tx_in_slot) begin
                tx_lfsr      <= {tx_lfsr[LFSR_LEN-2:0], tx_fb};
                tx_line_data <= tx_fb ^ INVERT;
            end else begin
                tx_line_data <= pin_sync[3];
            end
        end
    end

    // Self-synchronising checker
    assign rx_bit = pin_sync[0] ^ INVERT;
    assign rx_err = rx_bit != (rx_shift[TAP_A-1] ^ rx_shift[TAP_B-1]);
    assign next_win_cnt = win_cnt + {6'h00, rx_err}
                        - {6'h00, win_hist[WIN_LEN-1]};

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_idx <= '0;
        end else if (rx_rise) begin
            rx_idx <= next_rx_idx;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ck_state  <= CK_HUNT;
            rx_mode_d <= PM_NORMAL;
            rx_shift  <= '0;
            run_cnt   <= 8'h00;
            win_hist  <= '0;
            win_cnt   <= '0;
            err_evt   <= 1'b0;
            gain_evt  <= 1'b0;
            loss_evt  <= 1'b0;
        end else begin
            rx_mode_d <= mode_ctrl.rx_mode;
            err_evt   <= 1'b0;
            gain_evt  <= 1'b0;
            loss_evt  <= 1'b0;
            if (mode_ctrl.rx_mode != rx_mode_d
                    || mode_ctrl.rx_mode == PM_NORMAL) begin
                loss_evt <= ck_state == CK_SYNC;
                ck_state <= CK_HUNT;
                run_cnt  <= 8'h00;
                win_hist <= '0;
                win_cnt  <= '0;
            end else if (rx_rise && rx_in_slot) begin
                rx_shift <= {rx_shift[LFSR_LEN-2:0], rx_bit};
                unique case (ck_state)
                    CK_HUNT: begin
                        if (rx_err || rx_shift == '0) begin
                            run_cnt <= 8'h00;
                        end else if (run_cnt == 8'(SYNC_RUN_P - 1)) begin
                            ck_state <= CK_SYNC;
                            gain_evt <= 1'b1;
                            run_cnt  <= 8'h00;
                            win_hist <= '0;
                            win_cnt  <= '0;
                        end else begin
                            run_cnt <= run_cnt + 8'h01;
                        end
                    end
                    CK_SYNC: begin
                        err_evt  <= rx_err;
                        win_hist <= {win_hist[WIN_LEN-2:0], rx_err};
                        win_cnt  <= next_win_cnt;
                        if (next_win_cnt >= LOSS_ERRS) begin
                            ck_state <= CK_HUNT;
                            loss_evt <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign pattern_sync_flag = ck_state == CK_SYNC;

    // One receive-clock-wide error pulse on the user outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            err_pulse     <= 1'b0;
            user_output_a <= 1'b0;
            user_output_b <= 1'b0;
        end else begin
            if (rx_rise) begin
                err_pulse <= ck_state == CK_SYNC && rx_in_slot && rx_err
                             && mode_ctrl.rx_mode == rx_mode_d
                             && mode_ctrl.rx_mode != PM_NORMAL;
            end
            user_output_a <= err_pulse & out_sel[0];
            user_output_b <= err_pulse & out_sel[1];
        end
    end

    // APB access
    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign cnt_clr = wr_en && paddr == OFF_ERR_CNT;
    assign int_clr = (wr_en && paddr == OFF_INT_CLR)
                   ? pwdata[INT_W-1:0] : '0;

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_ctrl      <= MODE_RST;
            tx_slot_select <= SEL_RST;
            rx_slot_select <= SEL_RST;
            int_en         <= '0;
            out_sel        <= OUT_RST;
        end else if (wr_en) begin
            unique case (paddr)
                OFF_MODE:    mode_ctrl      <= pwdata[3:0];
                OFF_TX_CTRL: tx_slot_select <= pwdata[SLOT_W-1:0];
                OFF_RX_CTRL: rx_slot_select <= pwdata[SLOT_W-1:0];
                OFF_INT_EN:  int_en         <= pwdata[INT_W-1:0];
                OFF_OUT_SEL: out_sel        <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Shared error counter, saturating; clear by write
    assign err_inc = (mode_ctrl.rx_mode != PM_NORMAL) ? err_evt
                                                      : ebit_error;

    always_ff @(posedge clock) begin
        if (rst) begin
            err_cnt <= '0;
        end else begin
            if (cnt_clr) begin
                err_cnt <= {15'h0000, err_inc};
            end else if (err_inc && err_cnt != 16'hffff) begin
                err_cnt <= err_cnt + 16'h0001;
            end
        end
    end

    // Sticky interrupt status; a new event wins over a clear
    assign int_evt = {err_evt, loss_evt, gain_evt};

    always_ff @(posedge clock) begin
        if (rst) begin
            int_stat <= '0;
            irq      <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~int_clr) | int_evt;
            irq      <= |(((int_stat & ~int_clr) | int_evt) & int_en);
        end
    end

    always_comb begin
        rd_err = 1'b0;
        unique case (paddr)
            OFF_MODE:     rd_mux = {28'h0000000, mode_ctrl};
            OFF_TX_CTRL:  rd_mux = {27'h0000000, tx_slot_select};
            OFF_RX_CTRL:  rd_mux = {27'h0000000, rx_slot_select};
            OFF_STATUS:   rd_mux = {31'h00000000, pattern_sync_flag};
            OFF_ERR_CNT:  rd_mux = {16'h0000, err_cnt};
            OFF_INT_STAT: rd_mux = {29'h00000000, int_stat};
            OFF_INT_CLR:  rd_mux = 32'h00000000;
            OFF_INT_EN:   rd_mux = {29'h00000000, int_en};
            OFF_OUT_SEL:  rd_mux = {30'h00000000, out_sel};
            default: begin
                rd_mux = 32'h00000000;
                rd_err = 1'b1;
            end
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= rd_err;
        end
    end
endmodule // epg_prbs_top
`default_nettype wire

// ---- sim/epg_prbs_checker.sv ----
/* Concurrent checks on the pattern block's top-level ports.
   Assumes APB writes land when psel and penable are high (no waits). */
`timescale 1ns/10ps
`default_nettype none
module epg_prbs_checker import epg_pkg::*; #(
    parameter int SYNC_RUN_P = SYNC_RUN
) (
    // System
    input wire logic        clock,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Line and status
    input wire logic        tx_line_clk,
    input wire logic        tx_traffic,
    input wire logic        tx_line_data,
    input wire logic        pattern_sync_flag,
    input wire logic        user_output_a,
    input wire logic        irq
);
    logic             wr;
    logic [3:0]       mode_q;
    logic             sel_a_q;
    logic [INT_W-1:0] en_q;
    assign wr = psel && penable && pwrite;
    // Shadow of written control fields
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q  <= MODE_RST;
            sel_a_q <= 1'b0;
            en_q    <= '0;
        end else if (wr) begin
            if (paddr == OFF_MODE) mode_q <= pwdata[3:0];
            if (paddr == OFF_OUT_SEL) sel_a_q <= pwdata[0];
            if (paddr == OFF_INT_EN) en_q <= pwdata[INT_W-1:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_reset_hunt: assert property (
        $fell(rst) |-> !pattern_sync_flag[*3])
        else $error("sync flag high after reset");
    chk_normal_hunt: assert property (
        wr && paddr == OFF_MODE && pwdata[1:0] == 2'h0
        |-> ##6 !pattern_sync_flag)
        else $error("sync kept in normal receive mode");
    chk_idle_nolock: assert property (
        $rose(pattern_sync_flag) |-> mode_q[1:0] != 2'h0)
        else $error("lock with checker disabled");
    chk_pulse_len: assert property (
        $rose(user_output_a) |-> user_output_a[*8])
        else $error("error pulse shorter than a bit");
    chk_pulse_enable: assert property (
        $rose(user_output_a) |-> sel_a_q)
        else $error("error pulse on unassigned output");
    chk_traffic_pass: assert property (
        $rose(tx_line_clk) && mode_q[3:2] == 2'h0 |-> ##5
        mode_q[3:2] != 2'h0 || tx_line_data == $past(tx_traffic, 5))
        else $error("traffic not passed in normal mode");
    chk_unmapped_err: assert property (
        psel && !penable && paddr > OFF_OUT_SEL |=> pslverr)
        else $error("no error for unmapped address");
    chk_irq_source: assert property (
        $rose(irq) |-> $past(en_q) != '0)
        else $error("interrupt with all sources masked");
    cover property ($rose(pattern_sync_flag));
    cover property ($fell(pattern_sync_flag));
    cover property ($rose(user_output_a));
endmodule // epg_prbs_checker
bind epg_prbs_top epg_prbs_checker #(.SYNC_RUN_P(SYNC_RUN_P)) chk_u (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .tx_line_clk, .tx_traffic, .tx_line_data, .pattern_sync_flag,
    .user_output_a, .irq);
`default_nettype wire

// ---- sim/epg_line_partner.sv ----
/* Far-end E1 test set: line clock, frame marks, traffic and pattern.
   Assumes the bench starts it after reset and requests bit errors. */
`timescale 1ns/10ps
`default_nettype none
module epg_line_partner import epg_pkg::*; (
    // Bench control
    input  wire logic run,
    input  wire logic loopback,
    input  wire logic err_req,
    // Line
    input  wire logic tx_line_data,
    output logic      line_clk,
    output logic      tx_fsync,
    output logic      rx_fsync,
    output logic      traffic,
    output logic      rx_data
);
    logic [LFSR_LEN:1]    sr;
    logic [BIT_IDX_W-1:0] idx;
    logic                 fb;
    assign fb = sr[TAP_A] ^ sr[TAP_B];
    initial begin
        line_clk = 1'b0;
        forever begin
            #40;
            line_clk = run & ~line_clk;
        end
    end
    initial begin
        sr       = '1;
        idx      = '0;
        tx_fsync = 1'b0;
        rx_fsync = 1'b0;
        traffic  = 1'b0;
        rx_data  = 1'b0;
    end
    // Data moves mid-bit; looped data lags one bit, so does its mark
    always @(negedge line_clk) begin
        tx_fsync <= (idx == 8'hff);
        rx_fsync <= tx_fsync;
        idx      <= idx + 8'h01;
        traffic  <= idx[0];
        sr       <= {sr[LFSR_LEN-1:1], fb};
        rx_data  <= loopback ? tx_line_data : ~fb ^ err_req;
    end
endmodule // epg_line_partner
`default_nettype wire

// ---- sim/epg_prbs_top_tb_top.sv ----
/* Self-checking bench for the E1 pattern generator and checker.
   Assumes the far-end model epg_line_partner and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module epg_prbs_top_tb_top import epg_pkg::*;;
    typedef struct packed {
        logic [1:0] tx, rx;
        logic [4:0] slot;
        logic       lb, sync;
        logic [3:0] frames;
    } epg_row_t;
    logic        clock, rst, psel, penable, pwrite, ebit_error;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, tx_line_data, pattern_sync_flag;
    logic        user_output_a, user_output_b, irq, err;
    logic        run, loopback, err_req, line_clk, tx_fsync, rx_fsync;
    logic        traffic, rx_data;
    int          n_mismatch = 0, check_count = 0, hi_a = 0, hi_b = 0;
    int          base_a, base_b;
    epg_row_t    rows [7] = '{
        '{2'h3, 2'h3, 5'h00, 1'b1, 1'b1, 4'h2},
        '{2'h2, 2'h2, 5'h00, 1'b1, 1'b1, 4'h2},
        '{2'h1, 2'h1, 5'h05, 1'b1, 1'b1, 4'h8},
        '{2'h1, 2'h1, 5'h1f, 1'b1, 1'b1, 4'h8},
        '{2'h0, 2'h3, 5'h00, 1'b1, 1'b0, 4'h2},
        '{2'h3, 2'h0, 5'h00, 1'b1, 1'b0, 4'h2},
        '{2'h0, 2'h3, 5'h00, 1'b0, 1'b1, 4'h2}};
    epg_prbs_top dut_u (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tx_line_clk(line_clk), .tx_frame_sync(tx_fsync),
        .tx_traffic(traffic), .tx_line_data, .rx_line_clk(line_clk),
        .rx_frame_sync(rx_fsync), .rx_line_data(rx_data), .ebit_error,
        .pattern_sync_flag, .user_output_a, .user_output_b, .irq);
    epg_line_partner line_u (
        .run, .loopback, .err_req, .tx_line_data, .line_clk, .tx_fsync,
        .rx_fsync, .traffic, .rx_data);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // High time of the user outputs, in system cycles
    always @(negedge clock) begin
        if (user_output_a === 1'b1) hi_a++;
        if (user_output_b === 1'b1) hi_b++;
    end
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic bits(input int n);
        repeat (n * 8) @(posedge clock);
    endtask
    // One errored line bit, then a gap of clean bits
    task automatic flip(input int gap);
        err_req <= 1'b1;
        bits(1);
        err_req <= 1'b0;
        bits(gap);
    endtask
    task automatic pulse_ebit();
        @(posedge clock);
        ebit_error <= 1'b1;
        @(posedge clock);
        ebit_error <= 1'b0;
    endtask
    initial begin
        #900000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        {rst, psel, penable, pwrite, ebit_error} = 5'h10;
        paddr = 8'h00;
        pwdata = 32'h0;
        {run, loopback, err_req} = 3'h0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        run <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, OFF_MODE, 32'h0);
            apb(1'b1, OFF_TX_CTRL, {27'h0, rows[i].slot});
            apb(1'b1, OFF_RX_CTRL, {27'h0, rows[i].slot});
            loopback <= rows[i].lb;
            apb(1'b1, OFF_MODE, {28'h0, rows[i].tx, rows[i].rx});
            bits(256 * rows[i].frames);
            rchk(OFF_STATUS, {31'h0, rows[i].sync});
        end
        // Isolated errors while locked: three mismatches each
        apb(1'b1, OFF_OUT_SEL, 32'h1);
        apb(1'b1, OFF_ERR_CNT, 32'h0);
        apb(1'b1, OFF_INT_CLR, 32'h7);
        apb(1'b1, OFF_INT_EN, 32'h4);
        base_a = hi_a;
        base_b = hi_b;
        pulse_ebit();
        flip(70);
        rchk(OFF_INT_STAT, 32'h4);
        `CHK(irq, 1'b1)
        apb(1'b1, OFF_INT_EN, 32'h0);
        flip(80);
        rchk(OFF_ERR_CNT, 32'h6);
        rchk(OFF_STATUS, 32'h1);
        `CHK(hi_a - base_a, 48)
        `CHK(hi_b - base_b, 0)
        `CHK(irq, 1'b0)
        apb(1'b1, OFF_INT_CLR, 32'h7);
        rchk(OFF_INT_STAT, 32'h0);
        // Six mismatches inside 64 bits: loss, then relock
        flip(20);
        flip(100);
        rchk(OFF_INT_STAT, 32'h7);
        apb(1'b1, OFF_MODE, 32'h2);
        rchk(OFF_STATUS, 32'h0);
        // Normal receive mode counts framer E-bit errors
        apb(1'b1, OFF_MODE, 32'h0);
        apb(1'b1, OFF_ERR_CNT, 32'h0);
        repeat (3) pulse_ebit();
        rchk(OFF_ERR_CNT, 32'h3);
        apb(1'b1, OFF_ERR_CNT, 32'h5);
        rchk(OFF_ERR_CNT, 32'h0);
        // Second reset, then register reset values and unmapped access
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a <= 32; a += 4) begin
            rchk(8'(a), 32'h0);
            `CHK(err, 1'b0)
        end
        rchk(8'h24, 32'h0);
        `CHK(err, 1'b1)
        give_verdict();
    end
endmodule // epg_prbs_top_tb_top
`default_nettype wire
